// [logic/mcs_regs.svh]
// Purpose: Constants for the measurement command sequencer
// Assumes: Included by its bare name
// Notes: Error codes held as signed 16-bit values
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define MCS_ERR_NONE 16'sh0000
`define MCS_ERR_LIST_MODE 16'sd811
`define MCS_ERR_OUT_OF_MEM (-16'sd225)
`define MCS_ERR_INIT_IGNORED (-16'sd213)
`define MCS_COUNT_ONE 16'h0001
`define MCS_DELAY_ZERO 16'h0000
`define MCS_CMD_W 3
`define MCS_FUNC_W 4
`endif

// [logic/mcs_pkg.sv]
// Purpose: Types for the measurement command sequencer
// Assumes: Nothing
// Notes: Command codes are the host-side opcode encoding
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_CMD_NONE,
    MCS_CMD_CONFIGURE,
    MCS_CMD_CONF_QUERY,
    MCS_CMD_FETCH,
    MCS_CMD_READ,
    MCS_CMD_MEASURE,
    MCS_CMD_ABORT,
    MCS_CMD_INITIATE
  } mcs_cmd_t;
  typedef enum logic [1:0] {
    MCS_SRC_IMMEDIATE,
    MCS_SRC_BUS,
    MCS_SRC_EXTERNAL,
    MCS_SRC_TIMER
  } mcs_src_t;
endpackage : mcs_pkg

// [logic/mcs_out_queue.sv]
// Purpose: One-entry output queue for query answers
// Assumes: Host takes the word when addressed to talk
// Notes: Its full flag feeds the message-available flag
`timescale 1ns/1ps
`default_nettype none
module mcs_out_queue #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic talk,
  output logic full,
  output logic [DATA_W-1:0] data,
  output logic taken
);
  logic full_ff;
  logic nxt_full;
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] nxt_data;
  logic taken_ff;
  logic nxt_taken;
  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_full = full_ff;
    nxt_data = data_ff;
    nxt_taken = 1'b0;
    if (talk && full_ff)
    begin
      nxt_full = 1'b0;
      nxt_taken = 1'b1;
    end
    if (push)
    begin
      nxt_full = 1'b1;
      nxt_data = push_data;
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      full_ff <= 1'b0;
      data_ff <= '0;
      taken_ff <= 1'b0;
    end
    else if (ce)
    begin
      full_ff <= nxt_full;
      data_ff <= nxt_data;
      taken_ff <= nxt_taken;
    end
  end
  assign full = full_ff;
  assign data = data_ff;
  assign taken = taken_ff;
endmodule : mcs_out_queue
`default_nettype wire

// [logic/mcs_sequencer.sv]
// Purpose: Sequencer for high-level measurement commands
// Assumes: One command pulse at a time, inputs synchronous to clk
// Notes: Measurement engine outside; this block drives its controls
// Summary of operation
// - Configure selects function; query reports it
// - Configure resets chosen function's controls
// - Configure clears continuous initiation
// - Configure forces immediate trigger source
// - Configure loads trigger counts with one
// - Configure sets trigger delay zero
// - Configure places trigger model idle
// - Configure disables all math stages
// - Configure disables and aborts buffer storage
// - Configure resets auto-zero, disables scanning
// - Fetch only returns latest processed reading
// - Fetch repeats old reading until newer
// - Reading sent when host addresses talk
// - Fetch or read in list mode gives +811
// - Read runs abort, initiate, fetch in order
// - Read acquires sample count readings into buffer
// - Abort idles, or restarts if continuous
// - Initiate leaves idle; continuous gives error
// - Ignored initiate does not stop fetch
// - Count above one with stored readings: -225
// - Measure runs abort, configure, read in order
// - Queue holding message sets message-available flag
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_sequencer #(
  parameter int DATA_W = 32,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire mcs_pkg::mcs_cmd_t cmd_code,
  input wire logic [`MCS_FUNC_W-1:0] cmd_func,
  input wire logic cont_init_set,
  input wire logic math_set,
  input wire logic scan_set,
  input wire logic trig_set,
  input wire mcs_pkg::mcs_src_t trig_set_source,
  input wire logic [CNT_W-1:0] trig_set_count,
  input wire logic [CNT_W-1:0] trig_set_delay,
  input wire logic list_mode,
  input wire logic [CNT_W-1:0] sample_count,
  input wire logic [CNT_W-1:0] buffer_points,
  input wire logic reading_valid,
  input wire logic [DATA_W-1:0] reading_data,
  input wire logic meas_idle,
  input wire logic talk,
  output logic cmd_ready,
  output logic [`MCS_FUNC_W-1:0] active_func,
  output logic func_defaults,
  output logic cont_init,
  output mcs_pkg::mcs_src_t trig_source,
  output logic [CNT_W-1:0] trig_count,
  output logic [CNT_W-1:0] trig_delay,
  output logic trig_idle,
  output logic trig_restart,
  output logic math_enable,
  output logic buffer_enable,
  output logic buffer_abort,
  output logic autozero_default,
  output logic scan_enable,
  output logic [CNT_W-1:0] acquire_count,
  output logic error_valid,
  output logic [15:0] error_code,
  output logic [DATA_W-1:0] talk_data,
  output logic talk_valid,
  output logic message_available_flag
);
  typedef enum logic [2:0] {
    MCS_ST_IDLE,
    MCS_ST_ABORT,
    MCS_ST_CONFIG,
    MCS_ST_INIT,
    MCS_ST_WAIT,
    MCS_ST_FETCH
  } mcs_state_t;
  mcs_state_t st_ff, nxt_st;
  logic is_meas_ff, nxt_is_meas;
  logic [`MCS_FUNC_W-1:0] func_ff, nxt_func;
  logic [`MCS_FUNC_W-1:0] pend_func_ff, nxt_pend_func;
  logic defaults_ff, nxt_defaults;
  logic cont_ff, nxt_cont;
  mcs_pkg::mcs_src_t src_ff, nxt_src;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic [CNT_W-1:0] delay_ff, nxt_delay;
  logic idle_ff, nxt_idle;
  logic restart_ff, nxt_restart;
  logic math_ff, nxt_math;
  logic buf_en_ff, nxt_buf_en;
  logic buf_abort_ff, nxt_buf_abort;
  logic az_ff, nxt_az;
  logic scan_ff, nxt_scan;
  logic [CNT_W-1:0] acq_ff, nxt_acq;
  logic err_v_ff, nxt_err_v;
  logic [15:0] err_ff, nxt_err;
  logic [DATA_W-1:0] last_ff, nxt_last;
  logic ready_ff, nxt_ready;
  logic q_push;
  logic [DATA_W-1:0] q_push_data;
  logic q_full;
  logic [DATA_W-1:0] q_data;
  logic q_taken;
  logic talk_v_ff;
  logic [DATA_W-1:0] talk_d_ff;
  logic mav_ff;
  // ****************************************
  // Output queue
  // ****************************************
  mcs_out_queue #(
    .DATA_W(DATA_W)
  ) u_queue (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .push(q_push),
    .push_data(q_push_data),
    .talk(talk),
    .full(q_full),
    .data(q_data),
    .taken(q_taken)
  );
  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_is_meas = is_meas_ff;
    nxt_func = func_ff;
    nxt_pend_func = pend_func_ff;
    nxt_defaults = 1'b0;
    nxt_cont = cont_ff;
    nxt_src = src_ff;
    nxt_count = count_ff;
    nxt_delay = delay_ff;
    nxt_idle = idle_ff;
    nxt_restart = 1'b0;
    nxt_math = math_ff;
    nxt_buf_en = buf_en_ff;
    nxt_buf_abort = 1'b0;
    nxt_az = 1'b0;
    nxt_scan = scan_ff;
    nxt_acq = acq_ff;
    nxt_err_v = 1'b0;
    nxt_err = err_ff;
    nxt_last = last_ff;
    nxt_ready = ready_ff;
    q_push = 1'b0;
    q_push_data = last_ff;
    if (reading_valid)
    begin
      nxt_last = reading_data;
    end
    case (st_ff)
      MCS_ST_IDLE:
      begin
        nxt_ready = 1'b1;
        if (cmd_valid && ready_ff)
        begin
          nxt_pend_func = cmd_func;
          nxt_is_meas = (cmd_code == mcs_pkg::MCS_CMD_MEASURE);
          case (cmd_code)
            mcs_pkg::MCS_CMD_CONFIGURE:
            begin
              nxt_st = MCS_ST_CONFIG;
              nxt_ready = 1'b0;
            end
            mcs_pkg::MCS_CMD_CONF_QUERY:
            begin
              q_push = 1'b1;
              q_push_data = DATA_W'(func_ff);
            end
            mcs_pkg::MCS_CMD_FETCH:
            begin
              if (list_mode)
              begin
                nxt_err_v = 1'b1;
                nxt_err = `MCS_ERR_LIST_MODE;
              end
              else
              begin
                q_push = 1'b1;
                q_push_data = last_ff;
              end
            end
            mcs_pkg::MCS_CMD_READ, mcs_pkg::MCS_CMD_MEASURE:
            begin
              nxt_ready = 1'b0;
              nxt_st = MCS_ST_ABORT;
            end
            mcs_pkg::MCS_CMD_ABORT:
            begin
              if (cont_ff)
              begin
                nxt_restart = 1'b1;
              end
              else
              begin
                nxt_idle = 1'b1;
              end
            end
            mcs_pkg::MCS_CMD_INITIATE:
            begin
              if (cont_ff)
              begin
                nxt_err_v = 1'b1;
                nxt_err = `MCS_ERR_INIT_IGNORED;
              end
              else
              begin
                nxt_idle = 1'b0;
              end
            end
            default:
            begin
              nxt_st = MCS_ST_IDLE;
            end
          endcase
        end
      end
      MCS_ST_ABORT:
      begin
        if (cont_ff)
        begin
          nxt_restart = 1'b1;
        end
        else
        begin
          nxt_idle = 1'b1;
        end
        nxt_st = is_meas_ff ? MCS_ST_CONFIG : MCS_ST_INIT;
        if (!is_meas_ff && list_mode)
        begin
          nxt_err_v = 1'b1;
          nxt_err = `MCS_ERR_LIST_MODE;
          nxt_st = MCS_ST_IDLE;
        end
        else if (!is_meas_ff && sample_count > `MCS_COUNT_ONE
                 && buffer_points != '0)
        begin
          nxt_err_v = 1'b1;
          nxt_err = `MCS_ERR_OUT_OF_MEM;
          nxt_st = MCS_ST_IDLE;
        end
      end
      MCS_ST_CONFIG:
      begin
        nxt_func = pend_func_ff;
        nxt_defaults = 1'b1;
        nxt_cont = 1'b0;
        nxt_src = mcs_pkg::MCS_SRC_IMMEDIATE;
        nxt_count = CNT_W'(`MCS_COUNT_ONE);
        nxt_delay = CNT_W'(`MCS_DELAY_ZERO);
        nxt_idle = 1'b1;
        nxt_math = 1'b0;
        nxt_buf_en = 1'b0;
        nxt_buf_abort = 1'b1;
        nxt_az = 1'b1;
        nxt_scan = 1'b0;
        if (is_meas_ff)
        begin
          nxt_is_meas = 1'b0;
          nxt_st = MCS_ST_ABORT;
        end
        else
        begin
          nxt_st = MCS_ST_IDLE;
        end
      end
      MCS_ST_INIT:
      begin
        if (cont_ff)
        begin
          nxt_err_v = 1'b1;
          nxt_err = `MCS_ERR_INIT_IGNORED;
          nxt_st = MCS_ST_FETCH;
        end
        else
        begin
          nxt_idle = 1'b0;
          nxt_buf_en = 1'b1;
          nxt_acq = sample_count;
          nxt_st = MCS_ST_WAIT;
        end
      end
      MCS_ST_WAIT:
      begin
        if (meas_idle && !reading_valid)
        begin
          nxt_idle = 1'b1;
          nxt_st = MCS_ST_FETCH;
        end
      end
      MCS_ST_FETCH:
      begin
        q_push = 1'b1;
        q_push_data = last_ff;
        nxt_st = MCS_ST_IDLE;
      end
      default:
      begin
        nxt_st = MCS_ST_IDLE;
      end
    endcase
    // Host setup writes; a set beats a same-cycle clear
    if (cont_init_set)
    begin
      nxt_cont = 1'b1;
    end
    if (math_set)
    begin
      nxt_math = 1'b1;
    end
    if (scan_set)
    begin
      nxt_scan = 1'b1;
    end
    if (trig_set)
    begin
      nxt_src = trig_set_source;
      nxt_count = trig_set_count;
      nxt_delay = trig_set_delay;
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_ff <= MCS_ST_IDLE;
      is_meas_ff <= 1'b0;
      func_ff <= '0;
      pend_func_ff <= '0;
      defaults_ff <= 1'b0;
      cont_ff <= 1'b0;
      src_ff <= mcs_pkg::MCS_SRC_IMMEDIATE;
      count_ff <= CNT_W'(`MCS_COUNT_ONE);
      delay_ff <= CNT_W'(`MCS_DELAY_ZERO);
      idle_ff <= 1'b1;
      restart_ff <= 1'b0;
      math_ff <= 1'b0;
      buf_en_ff <= 1'b0;
      buf_abort_ff <= 1'b0;
      az_ff <= 1'b0;
      scan_ff <= 1'b0;
      acq_ff <= '0;
      err_v_ff <= 1'b0;
      err_ff <= `MCS_ERR_NONE;
      last_ff <= '0;
      ready_ff <= 1'b0;
      talk_v_ff <= 1'b0;
      talk_d_ff <= '0;
      mav_ff <= 1'b0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      is_meas_ff <= nxt_is_meas;
      func_ff <= nxt_func;
      pend_func_ff <= nxt_pend_func;
      defaults_ff <= nxt_defaults;
      cont_ff <= nxt_cont;
      src_ff <= nxt_src;
      count_ff <= nxt_count;
      delay_ff <= nxt_delay;
      idle_ff <= nxt_idle;
      restart_ff <= nxt_restart;
      math_ff <= nxt_math;
      buf_en_ff <= nxt_buf_en;
      buf_abort_ff <= nxt_buf_abort;
      az_ff <= nxt_az;
      scan_ff <= nxt_scan;
      acq_ff <= nxt_acq;
      err_v_ff <= nxt_err_v;
      err_ff <= nxt_err;
      last_ff <= nxt_last;
      ready_ff <= nxt_ready;
      talk_v_ff <= q_taken;
      talk_d_ff <= q_data;
      mav_ff <= q_full || q_push;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign cmd_ready = ready_ff;
  assign active_func = func_ff;
  assign func_defaults = defaults_ff;
  assign cont_init = cont_ff;
  assign trig_source = src_ff;
  assign trig_count = count_ff;
  assign trig_delay = delay_ff;
  assign trig_idle = idle_ff;
  assign trig_restart = restart_ff;
  assign math_enable = math_ff;
  assign buffer_enable = buf_en_ff;
  assign buffer_abort = buf_abort_ff;
  assign autozero_default = az_ff;
  assign scan_enable = scan_ff;
  assign acquire_count = acq_ff;
  assign error_valid = err_v_ff;
  assign error_code = err_ff;
  assign talk_data = talk_d_ff;
  assign talk_valid = talk_v_ff;
  assign message_available_flag = mav_ff;
endmodule : mcs_sequencer
`default_nettype wire

// [sim/mcs_assertions.sv]
// Purpose: Port assertions for the command sequencer
// Assumes: Bound onto mcs_sequencer by the bench
// Notes: Error codes compared as 16-bit patterns
`timescale 1ns/1ps
`default_nettype none
module mcs_chk #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire mcs_pkg::mcs_cmd_t cmd_code,
  input wire logic [3:0] cmd_func,
  input wire logic list_mode,
  input wire logic [CNT_W-1:0] sample_count,
  input wire logic [CNT_W-1:0] buffer_points,
  input wire logic talk,
  input wire logic cmd_ready,
  input wire logic [3:0] active_func,
  input wire logic func_defaults,
  input wire logic cont_init,
  input wire mcs_pkg::mcs_src_t trig_source,
  input wire logic [CNT_W-1:0] trig_count,
  input wire logic [CNT_W-1:0] trig_delay,
  input wire logic trig_idle,
  input wire logic math_enable,
  input wire logic buffer_enable,
  input wire logic buffer_abort,
  input wire logic autozero_default,
  input wire logic scan_enable,
  input wire logic error_valid,
  input wire logic [15:0] error_code,
  input wire logic talk_valid,
  input wire logic message_available_flag
);
  // ******************************
  // Command takes and properties
  // ******************************
  logic tk, cf, rd, ft, it;
  assign tk = ce && cmd_valid && cmd_ready;
  assign cf = tk && cmd_code == mcs_pkg::MCS_CMD_CONFIGURE;
  assign rd = tk && cmd_code == mcs_pkg::MCS_CMD_READ;
  assign ft = tk && cmd_code == mcs_pkg::MCS_CMD_FETCH;
  assign it = tk && cmd_code == mcs_pkg::MCS_CMD_INITIATE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  cfg_func_a: assert property (cf |-> ##3
    active_func == $past(cmd_func, 3)) else $error("cfg func");
  cfg_trig_a: assert property (cf |-> ##3
    trig_source == mcs_pkg::MCS_SRC_IMMEDIATE && trig_count == 1
    && trig_delay == 0) else $error("cfg trigger");
  cfg_mode_a: assert property (cf |-> ##3
    !cont_init && trig_idle && !math_enable && !buffer_enable
    && !scan_enable) else $error("cfg mode");
  cfg_pulse_a: assert property (cf |-> ##[1:3]
    func_defaults && buffer_abort && autozero_default) else $error("pulse");
  list_err_a: assert property ((rd || ft) && list_mode |-> ##[1:4]
    error_valid && error_code == 16'h032b) else $error("list err");
  mem_err_a: assert property (rd && !list_mode && sample_count > 1
    && buffer_points != 0 |-> ##[1:4] error_valid && error_code == 16'hff1f)
    else $error("mem err");
  init_err_a: assert property (it && cont_init |-> ##[1:3]
    error_valid && error_code == 16'hff2b) else $error("init err");
  talk_out_a: assert property (talk && message_available_flag |->
    ##[1:3] talk_valid) else $error("talk");
  flag_drop_a: assert property ($fell(message_available_flag) |->
    talk_valid || $past(talk_valid)) else $error("flag drop");
  fetch_flag_a: assert property (ft && !list_mode |->
    ##[1:3] message_available_flag) else $error("fetch flag");
endmodule : mcs_chk
`default_nettype wire

// [sim/mcs_engine_model.sv]
// Purpose: Measurement engine stand-in for the sequencer
// Assumes: Acquires while the trigger model is out of idle
// Notes: One reading every four cycles
`timescale 1ns/1ps
`default_nettype none
module mcs_engine_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic trig_idle,
  input wire logic [15:0] acquire_count,
  output var logic reading_valid,
  output var logic [31:0] reading_data,
  output logic meas_idle
);
  // ******************************
  // Acquisition
  // ******************************
  logic [15:0] n_ff;
  logic [1:0] gap_ff;
  logic done_ff;
  assign meas_idle = trig_idle || done_ff;
  always @(posedge clk)
  begin
    reading_valid <= 1'b0;
    if (!rstn)
      reading_data <= 32'h0000_0000;
    if (!rstn || trig_idle)
    begin
      n_ff <= 16'h0000;
      gap_ff <= 2'h0;
      done_ff <= 1'b0;
    end
    else if (n_ff == acquire_count)
      done_ff <= 1'b1;
    else
    begin
      gap_ff <= gap_ff + 2'h1;
      if (gap_ff == 2'h3)
      begin
        reading_valid <= 1'b1;
        reading_data <= reading_data + 32'h0001_0003;
        n_ff <= n_ff + 16'h0001;
      end
    end
  end
endmodule : mcs_engine_model
`default_nettype wire

// [sim/mcs_sequencer_tb.sv]
// Purpose: Self-checking bench for the command sequencer
// Assumes: Engine model answers each initiate
// Notes: Outputs logged in queues, compared with expected values
`timescale 1ns/1ps
`default_nettype none
module mcs_sequencer_tb;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, cmd_valid = 1'b0, talk = 1'b0;
  logic cont_init_set = 1'b0, list_mode = 1'b0;
  logic math_set = 1'b0, scan_set = 1'b0, trig_set = 1'b0;
  logic reading_valid, meas_idle, cmd_ready, func_defaults, cont_init;
  logic trig_idle, trig_restart, math_enable, buffer_enable, buffer_abort;
  logic autozero_default, scan_enable, error_valid, talk_valid;
  logic message_available_flag;
  mcs_pkg::mcs_cmd_t cmd_code = mcs_pkg::MCS_CMD_NONE;
  mcs_pkg::mcs_src_t trig_source;
  mcs_pkg::mcs_src_t trig_set_source = mcs_pkg::MCS_SRC_IMMEDIATE;
  logic [3:0] cmd_func = 4'h0, active_func, f;
  logic [15:0] sample_count = 16'h0001, buffer_points = 16'h0000;
  logic [15:0] trig_count, trig_delay, acquire_count, error_code, sc;
  logic [15:0] trig_set_count = 16'h0000, trig_set_delay = 16'h0000;
  logic [31:0] reading_data, talk_data, last_rd = 32'h0000_0000;
  logic [4:0] lv;
  logic [31:0] q_t[$];
  logic [15:0] q_e[$];
  int n_errors, n_checks, cyc, n_rd, r0, n_rs;
  int seed = 32'hf18e;
  assign lv = {cont_init, trig_idle, math_enable, buffer_enable, scan_enable};
  mcs_sequencer dut (.*);
  mcs_engine_model eng (.*);
  // ******************************
  // Clock, monitor and tasks
  // ******************************
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (reading_valid)
      n_rd++;
    if (reading_valid)
      last_rd = reading_data;
    if (trig_restart)
      n_rs++;
    if (talk_valid)
      q_t.push_back(talk_data);
    if (error_valid)
      q_e.push_back(error_code);
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input mcs_pkg::mcs_cmd_t c, input logic [3:0] fn);
    @(negedge clk);
    while (!cmd_ready) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_func <= fn;
    @(posedge clk) cmd_valid <= 1'b0;
    repeat (3) @(negedge clk);
    while (!cmd_ready) @(negedge clk);
  endtask : go
  task automatic tk(input logic [31:0] e);
    chk(message_available_flag, 1'b1);
    @(posedge clk) talk <= 1'b1;
    @(posedge clk) talk <= 1'b0;
    repeat (3) @(negedge clk);
    chk(q_t.size() ? q_t.pop_front() : 'x, e);
  endtask : tk
  task automatic ec(input logic [15:0] e);
    chk(q_e.size() ? q_e.pop_front() : 'x, e);
  endtask : ec
  task automatic cis;
    @(posedge clk);
    cont_init_set <= 1'b1;
    math_set <= 1'b1;
    scan_set <= 1'b1;
    trig_set <= 1'b1;
    trig_set_source <= mcs_pkg::mcs_src_t'(2'($random(seed)) | 2'h1);
    trig_set_count <= 16'($random(seed)) | 16'h0002;
    trig_set_delay <= 16'($random(seed)) | 16'h0001;
    @(posedge clk);
    cont_init_set <= 1'b0;
    math_set <= 1'b0;
    scan_set <= 1'b0;
    trig_set <= 1'b0;
  endtask : cis
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // ******************************
  // Scenarios
  // ******************************
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    go(mcs_pkg::MCS_CMD_FETCH, 4'h0);
    tk(32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      sc = 16'(1 + $unsigned($random(seed)) % 4);
      @(posedge clk) sample_count <= sc;
      r0 = n_rd;
      go(mcs_pkg::MCS_CMD_READ, 4'h0);
      chk(acquire_count, sc);
      chk(n_rd - r0, sc);
      tk(last_rd);
      go(mcs_pkg::MCS_CMD_FETCH, 4'h0);
      tk(last_rd);
      f = 4'($unsigned($random(seed)) % 12);
      cis();
      go(mcs_pkg::MCS_CMD_CONFIGURE, f);
      chk({active_func, trig_source}, {f, 2'h0});
      chk(lv, 5'h08);
      chk({trig_count, trig_delay}, 32'h0001_0000);
      go(mcs_pkg::MCS_CMD_CONF_QUERY, 4'h0);
      tk({28'h000_0000, f});
    end
    cis();
    go(mcs_pkg::MCS_CMD_INITIATE, 4'h0);
    ec(16'hff2b);
    go(mcs_pkg::MCS_CMD_READ, 4'h0);
    ec(16'hff2b);
    tk(last_rd);
    chk(n_rs, 1);
    f = 4'($unsigned($random(seed)) % 12);
    go(mcs_pkg::MCS_CMD_MEASURE, f);
    chk(active_func, f);
    chk(q_e.size(), 0);
    chk(lv, 5'h0a);
    chk({trig_count, trig_delay}, 32'h0001_0000);
    tk(last_rd);
    go(mcs_pkg::MCS_CMD_INITIATE, 4'h0);
    chk(trig_idle, 1'b0);
    go(mcs_pkg::MCS_CMD_ABORT, 4'h0);
    chk(trig_idle, 1'b1);
    chk(n_rs, 2);
    @(posedge clk) ce <= 1'b0;
    cis();
    @(posedge clk) ce <= 1'b1;
    @(negedge clk);
    chk({13'h0000, cont_init, math_enable, scan_enable, trig_count},
      32'h0000_0001);
    @(posedge clk) list_mode <= 1'b1;
    go(mcs_pkg::MCS_CMD_READ, 4'h0);
    ec(16'h032b);
    go(mcs_pkg::MCS_CMD_FETCH, 4'h0);
    ec(16'h032b);
    chk(message_available_flag, 1'b0);
    @(posedge clk) list_mode <= 1'b0;
    sample_count <= 16'h0002;
    buffer_points <= 16'h0005;
    go(mcs_pkg::MCS_CMD_READ, 4'h0);
    ec(16'hff1f);
    @(posedge clk) sample_count <= 16'h0001;
    go(mcs_pkg::MCS_CMD_READ, 4'h0);
    chk(q_e.size(), 0);
    tk(last_rd);
    finish_test();
  end
endmodule : mcs_sequencer_tb
bind mcs_sequencer mcs_chk #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire
